/* common/stdb_defines.svh */
// Constants of the serial transmit datapath with self test.
`ifndef STDB_DEFINES_SVH
`define STDB_DEFINES_SVH
`define STDB_WORD_W8 4'h8
`define STDB_WORD_W10 4'hA
`define STDB_MULT_MIN 5'h0A
`define STDB_MULT_MAX 5'h14
`define STDB_MAX_RUN_LEN 7'h0A
`define STDB_RUN_ONE 7'h01
`define STDB_IDLE_RAW 10'h155
`define STDB_IDLE_BYTE 8'hBC
`define STDB_K28_6B 6'h0F
`define STDB_A7_4B 4'h7
`define STDB_PRBS_SEED 10'h3FF
`define STDB_SER_RESET 10'h000
`endif

/* common/stdb_pkg.sv */
// Types shared by the serial transmit datapath.
package stdb_pkg;
    typedef enum logic [1:0] {
        REF_GLOBAL = 2'h0,
        REF_IO_BUS = 2'h1,
        REF_GENERIC = 2'h2,
        REF_LOCAL = 2'h3
    } stdb_refsel_e;

    typedef enum logic [1:0] {
        MUX_IDLE = 2'h0,
        MUX_HIGH = 2'h1
    } stdb_mux_e;

    typedef struct packed {
        logic [1:0] is_k;
        logic [19:0] data;
    } stdb_fab_word_s;

    typedef struct packed {
        logic enc_bypass;
        logic double_width;
        logic word_width_10;
        logic fifo_enable;
        logic fab_div2;
        stdb_refsel_e ref_sel;
        logic chan_clk_sel;
        logic xaui_mode;
        logic [4:0] mult_factor;
        logic bist_width10;
        logic line_loopback;
    } stdb_cfg_s;
endpackage

/* src/stdb_enc8b10b.sv */
// Combinational 8b/10b character encoder with running disparity in and out.
`timescale 1ns/1ps
`include "stdb_defines.svh"
module stdb_enc8b10b
    import stdb_pkg::*;
(
    // Character in
    input wire logic [7:0] byte_in,
    input wire logic is_k,
    input wire logic rd_in,
    // Code out, bit 9 is sent first
    output logic [9:0] code,
    output logic rd_out
);
    localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] c6;
    logic [3:0] c4;
    logic un6;
    logic un4;
    logic rd6;
    logic alt7;

    assign x = byte_in[4:0];
    assign y = byte_in[7:5];

    always_comb begin
        c6 = is_k ? `STDB_K28_6B : T6[x];
        un6 = ($countones(c6) != 3);
        if (rd_in && (un6 || (x == 5'h07 && !is_k))) begin
            c6 = ~c6;
        end
        rd6 = rd_in ^ un6;
        alt7 = (y == 3'h7) && (is_k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
            (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        c4 = alt7 ? `STDB_A7_4B : T4[y];
        if (is_k && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6)) begin
            c4 = ~c4;
        end
        un4 = ($countones(c4) != 2);
        // K pairs are complements, so a K half flips on positive disparity even when balanced.
        if (rd6 && (un4 || y == 3'h3 || is_k)) begin
            c4 = ~c4;
        end
        code = {c6, c4};
        rd_out = rd6 ^ un4;
    end
endmodule

/* src/stdb_prbs.sv */
// Pattern generator and self-synchronising bit-serial verifier for self test.
`timescale 1ns/1ps
`include "stdb_defines.svh"
module stdb_prbs
    import stdb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pattern control
    input wire logic width10,
    input wire logic enable,
    input wire logic gen_step,
    output logic [9:0] gen_word,
    // Verifier
    input wire logic chk_valid,
    input wire logic chk_bit,
    output logic chk_error
);
    logic [9:0] gen_r;
    logic [9:0] gen_adv;
    logic [9:0] chk_r;
    logic [3:0] train_r;

    function automatic logic fb(input logic [9:0] s, input logic w10);
        fb = w10 ? (s[9] ^ s[6]) : (s[7] ^ s[5] ^ s[4] ^ s[3]);
    endfunction

    always_comb begin
        logic b;
        b = 1'b0;
        gen_adv = gen_r;
        gen_word = 10'h000;
        for (int i = 0; i < 10; i++) begin
            if (width10 || i < 8) begin
                b = fb(gen_adv, width10);
                gen_adv = {gen_adv[8:0], b};
                gen_word[9 - i] = b;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_r <= `STDB_PRBS_SEED;
        end else if (!enable) begin
            gen_r <= `STDB_PRBS_SEED;
        end else if (gen_step) begin
            gen_r <= gen_adv;
        end
    end

    // The verifier loads its first bits as state, so any loop latency is absorbed.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_r <= `STDB_SER_RESET;
            train_r <= 4'h0;
            chk_error <= 1'b0;
        end else if (!enable) begin
            train_r <= 4'h0;
            chk_error <= 1'b0;
        end else if (chk_valid) begin
            chk_r <= {chk_r[8:0], chk_bit};
            if (train_r < (width10 ? `STDB_WORD_W10 : `STDB_WORD_W8)) begin
                train_r <= train_r + 4'h1;
            end else if (chk_bit != fb(chk_r, width10)) begin
                chk_error <= 1'b1;
            end
        end
    end
endmodule

/* src/stdb_top.sv */
// Transmit channel datapath: fabric crossing, width multiplexer, encoder, serializer and self test.
`timescale 1ns/1ps
`include "stdb_defines.svh"
module stdb_top
    import stdb_pkg::*;
#(
    parameter int RUN_CNT_W = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fabric transmit word, new word marked by a toggle
    input wire stdb_fab_word_s fab_word,
    input wire logic fab_word_toggle,
    // Configuration and self test
    input wire stdb_cfg_s cfg,
    input wire logic self_test_enable,
    // Clock sources and receive loop
    input wire logic [3:0] ref_clk_in,
    input wire logic master_channel_tx_clock,
    input wire logic rx_serial_in,
    // Serial line
    output logic tx_serial_out,
    output logic tx_out_enable,
    // Clock outputs
    output logic tx_reference_clock,
    output logic channel_clock,
    output logic word_clock,
    output logic fabric_clock,
    output logic mux_clock_source,
    // Status
    output logic self_test_error,
    output logic pll_cfg_error,
    output logic run_length_error
);
    localparam int SYNC_W = $bits(stdb_fab_word_s) + $bits(stdb_cfg_s) + 8;

    logic [SYNC_W-1:0] sync_in;
    wire [SYNC_W-1:0] sync_s;
    stdb_fab_word_s fab_s;
    stdb_cfg_s cfg_s;
    logic tog_s;
    logic bist_s;
    logic [3:0] ref_s;
    logic master_s;
    logic rx_s;

    assign sync_in = {fab_word, cfg, fab_word_toggle, self_test_enable, ref_clk_in,
        master_channel_tx_clock, rx_serial_in};

    // Two flops on every bit coming from outside the channel clock.
    for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_sync
        logic q1_r;
        logic q2_r;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                q1_r <= 1'b0;
                q2_r <= 1'b0;
            end else begin
                q1_r <= sync_in[gi];
                q2_r <= q1_r;
            end
        end
        assign sync_s[gi] = q2_r;
    end

    assign {fab_s, cfg_s, tog_s, bist_s, ref_s, master_s, rx_s} = sync_s;

    logic tog_d_r;
    logic new_word;
    logic pend_r;
    stdb_fab_word_s hold_r;
    stdb_mux_e mux_st_r;
    logic [9:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic is_prbs_r;
    logic rd_r;
    logic load;
    logic ser10;
    logic half_w10;
    logic [3:0] word_w;
    logic take_low;
    logic take_high;
    logic idle;
    logic [9:0] cur_half;
    logic cur_k;
    logic [9:0] word_nxt;
    logic [9:0] enc_code;
    logic enc_rd;
    logic [9:0] gen_word;
    logic prbs_err;
    logic local_loop;

    // The data bus settled before its toggle, so it is taken as the toggle edge arrives.
    assign new_word = (tog_s ^ tog_d_r) && !bist_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_d_r <= 1'b0;
        end else begin
            tog_d_r <= tog_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= '0;
        end else if (new_word) begin
            hold_r <= fab_s;
        end
    end

    // A word arriving as the old one is consumed is kept: the set wins.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
        end else if (new_word) begin
            pend_r <= 1'b1;
        end else if (bist_s) begin
            pend_r <= 1'b0;
        end else if (take_low) begin
            pend_r <= 1'b0;
        end
    end

    assign ser10 = bist_s ? cfg_s.bist_width10 : (!cfg_s.enc_bypass || cfg_s.word_width_10);
    assign word_w = ser10 ? `STDB_WORD_W10 : `STDB_WORD_W8;
    assign half_w10 = cfg_s.enc_bypass && cfg_s.word_width_10;
    assign load = (bit_cnt_r == 4'h0);
    assign take_low = load && !bist_s && (mux_st_r == MUX_IDLE) && pend_r;
    assign take_high = load && !bist_s && (mux_st_r == MUX_HIGH);
    assign idle = !take_low && !take_high;

    // Low half goes first, the high half one word period later.
    always_comb begin
        if (take_high) begin
            cur_half = half_w10 ? hold_r.data[19:10] : {2'b00, hold_r.data[15:8]};
            cur_k = hold_r.is_k[1];
        end else begin
            cur_half = half_w10 ? hold_r.data[9:0] : {2'b00, hold_r.data[7:0]};
            cur_k = hold_r.is_k[0];
        end
    end

    // An empty slot sends a comma when encoding, else an alternating pattern.
    stdb_enc8b10b u_enc (
        .byte_in(idle ? `STDB_IDLE_BYTE : cur_half[7:0]),
        .is_k(idle || cur_k),
        .rd_in(rd_r),
        .code(enc_code),
        .rd_out(enc_rd)
    );

    always_comb begin
        if (bist_s) begin
            word_nxt = gen_word;
        end else if (!cfg_s.enc_bypass) begin
            word_nxt = enc_code;
        end else if (idle) begin
            word_nxt = `STDB_IDLE_RAW;
        end else begin
            word_nxt = half_w10 ? cur_half : {cur_half[7:0], 2'b00};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_st_r <= MUX_IDLE;
        end else begin
            unique case (mux_st_r)
                MUX_IDLE: begin
                    if (take_low && cfg_s.double_width) begin
                        mux_st_r <= MUX_HIGH;
                    end
                end
                MUX_HIGH: begin
                    if (take_high || bist_s) begin
                        mux_st_r <= MUX_IDLE;
                    end
                end
                default: begin
                    mux_st_r <= MUX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_r <= 1'b0;
        end else if (load && !bist_s && !cfg_s.enc_bypass) begin
            rd_r <= enc_rd;
        end
    end

    // One serial bit per clock; the word period is 8 or 10 clocks.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= `STDB_SER_RESET;
            bit_cnt_r <= 4'h0;
            is_prbs_r <= 1'b0;
        end else if (load) begin
            shift_r <= word_nxt;
            bit_cnt_r <= word_w - 4'h1;
            is_prbs_r <= bist_s;
        end else begin
            shift_r <= {shift_r[8:0], 1'b0};
            bit_cnt_r <= bit_cnt_r - 4'h1;
        end
    end

    assign local_loop = bist_s && !cfg_s.line_loopback;

    logic loop_bit_r;
    logic tag_r;
    logic tag_d1_r;
    logic tag_d2_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_serial_out <= 1'b0;
            tx_out_enable <= 1'b0;
            loop_bit_r <= 1'b0;
            tag_r <= 1'b0;
            tag_d1_r <= 1'b0;
            tag_d2_r <= 1'b0;
        end else begin
            tx_serial_out <= local_loop ? 1'b0 : shift_r[9];
            tx_out_enable <= !local_loop;
            loop_bit_r <= shift_r[9];
            tag_r <= is_prbs_r;
            tag_d1_r <= tag_r;
            tag_d2_r <= tag_d1_r;
        end
    end

    // Line loopback returns through the pin synchronizer, hence the two-cycle tag delay.
    stdb_prbs u_prbs (
        .clk(clk),
        .rst_n(rst_n),
        .width10(cfg_s.bist_width10),
        .enable(bist_s),
        .gen_step(load && bist_s),
        .gen_word(gen_word),
        .chk_valid(cfg_s.line_loopback ? tag_d2_r : tag_r),
        .chk_bit(cfg_s.line_loopback ? rx_s : loop_bit_r),
        .chk_error(prbs_err)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            self_test_error <= 1'b0;
        end else begin
            self_test_error <= prbs_err;
        end
    end

    logic last_bit_r;
    logic [RUN_CNT_W-1:0] run_cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_bit_r <= 1'b0;
            run_cnt_r <= '0;
            run_length_error <= 1'b0;
            pll_cfg_error <= 1'b0;
        end else begin
            last_bit_r <= tx_serial_out;
            if (tx_serial_out != last_bit_r) begin
                run_cnt_r <= RUN_CNT_W'(`STDB_RUN_ONE);
            end else if (run_cnt_r != '1) begin
                run_cnt_r <= run_cnt_r + RUN_CNT_W'(`STDB_RUN_ONE);
            end
            run_length_error <= cfg_s.xaui_mode && tx_out_enable && (run_cnt_r > `STDB_MAX_RUN_LEN);
            pll_cfg_error <= cfg_s.xaui_mode &&
                ((cfg_s.mult_factor < `STDB_MULT_MIN) || (cfg_s.mult_factor > `STDB_MULT_MAX));
        end
    end

    logic fab_div_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_clock <= 1'b0;
            fab_div_r <= 1'b0;
            fabric_clock <= 1'b0;
        end else begin
            word_clock <= (bit_cnt_r >= (word_w >> 1));
            if (load) begin
                fab_div_r <= !fab_div_r;
            end
            fabric_clock <= cfg_s.fab_div2 ? fab_div_r : word_clock;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_reference_clock <= 1'b0;
            channel_clock <= 1'b0;
            mux_clock_source <= 1'b0;
        end else begin
            unique case (cfg_s.ref_sel)
                REF_GLOBAL: tx_reference_clock <= ref_s[0];
                REF_IO_BUS: tx_reference_clock <= ref_s[1];
                REF_GENERIC: tx_reference_clock <= ref_s[2];
                REF_LOCAL: tx_reference_clock <= ref_s[3];
            endcase
            channel_clock <= cfg_s.chan_clk_sel ? master_s : tx_reference_clock;
            mux_clock_source <= cfg_s.fifo_enable;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_low_issue;
        take_low && cfg_s.double_width;
    endsequence

    sequence s_high_raw10;
        take_high && cfg_s.enc_bypass && cfg_s.word_width_10;
    endsequence

    chk_low_half_first: assert property (s_low_issue |=> mux_st_r == MUX_HIGH)
        else $error("double width did not wait for the high half");
    chk_high_half_data: assert property (s_high_raw10 |=> shift_r == $past(hold_r.data[19:10]))
        else $error("high half not loaded after low half");
    chk_bypass_single: assert property (take_low && !cfg_s.double_width && !new_word
        |=> !pend_r && mux_st_r == MUX_IDLE)
        else $error("single width word not passed straight");
    chk_enc_balance: assert property (load && !bist_s && !cfg_s.enc_bypass
        |=> $countones(shift_r) >= 4 && $countones(shift_r) <= 6)
        else $error("encoded character unbalanced");
    chk_word_period: assert property (load |=> !load [*7])
        else $error("word period shorter than eight bits");
    chk_bist_feeds_ser: assert property (load && bist_s |=> is_prbs_r && shift_r == $past(gen_word))
        else $error("pattern word not loaded in self test");
    chk_bist_drops_fab: assert property (bist_s |=> !pend_r)
        else $error("fabric word kept during self test");
    chk_local_quiet: assert property (bist_s && !cfg_s.line_loopback |=> !tx_out_enable && !tx_serial_out)
        else $error("local loopback drives the line");
    chk_error_clear: assert property ((!bist_s) [*2] |=> !self_test_error)
        else $error("self test error not cleared");
    chk_error_hold: assert property (self_test_error && bist_s |=> self_test_error || !bist_s)
        else $error("self test error dropped while enabled");
    chk_mult_range: assert property (cfg_s.xaui_mode && cfg_s.mult_factor > `STDB_MULT_MAX |=> pll_cfg_error)
        else $error("multiplication factor out of range not flagged");
    chk_run_limit: assert property (cfg_s.xaui_mode && tx_out_enable && run_cnt_r > `STDB_MAX_RUN_LEN
        |=> run_length_error)
        else $error("run length over limit not flagged");
endmodule

/* testbench/stdb_link_partner.sv */
// Serial link partner that returns the transmitted line for line loopback.
`timescale 1ns/1ps
module stdb_link_partner (
    // Line from the channel
    input wire logic clk,
    input wire logic tx_serial_out,
    input wire logic tx_out_enable,
    // Commanded bit fault on the return path
    input wire logic corrupt,
    // Returned line
    output logic rx_serial_in
);
    logic last_r;

    always_ff @(posedge clk) begin
        last_r <= rx_serial_in;
    end

    // A released line shows the inverse of its last value, so a stale bit never passes for data.
    always_comb begin
        rx_serial_in = tx_out_enable ? (tx_serial_out ^ corrupt) : ~last_r;
    end
endmodule

/* testbench/stdb_top_tb.sv */
// Self-checking bench of the serial transmit datapath.
`timescale 1ns/1ps
module stdb_top_tb;
    import stdb_pkg::*;
    logic clk;
    logic rst_n;
    stdb_fab_word_s fab_word;
    logic fab_word_toggle;
    stdb_cfg_s cfg;
    logic self_test_enable;
    logic [3:0] ref_clk_in;
    logic master_channel_tx_clock;
    logic rx_serial_in;
    logic corrupt;
    logic tx_serial_out, tx_out_enable, tx_reference_clock, channel_clock, word_clock;
    logic fabric_clock, mux_clock_source, self_test_error, pll_cfg_error, run_length_error;
    logic [19:0] hist = '0;
    logic wq = 1'b0;
    logic fq = 1'b0;
    logic hit, rl, st;
    logic [4:0] mults [4] = '{5'h09, 5'h0A, 5'h14, 5'h15};
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int wr = 0;
    int fr = 0;
    int w0, f0, rs, rmax, rmin;

    stdb_top uut (.clk(clk), .rst_n(rst_n), .fab_word(fab_word), .fab_word_toggle(fab_word_toggle),
        .cfg(cfg), .self_test_enable(self_test_enable), .ref_clk_in(ref_clk_in),
        .master_channel_tx_clock(master_channel_tx_clock), .rx_serial_in(rx_serial_in),
        .tx_serial_out(tx_serial_out), .tx_out_enable(tx_out_enable), .tx_reference_clock(tx_reference_clock),
        .channel_clock(channel_clock), .word_clock(word_clock), .fabric_clock(fabric_clock),
        .mux_clock_source(mux_clock_source), .self_test_error(self_test_error),
        .pll_cfg_error(pll_cfg_error), .run_length_error(run_length_error));

    stdb_link_partner partner (.clk(clk), .tx_serial_out(tx_serial_out), .tx_out_enable(tx_out_enable),
        .corrupt(corrupt), .rx_serial_in(rx_serial_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // The ceiling sits well above the roughly two thousand cycles the tests need.
    always @(posedge clk) begin
        hist <= {hist[18:0], tx_serial_out};
        wq <= word_clock;
        fq <= fabric_clock;
        wr <= wr + int'(word_clock & ~wq);
        fr <= fr + int'(fabric_clock & ~fq);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data settles one cycle before the toggle flips and then holds for the whole wait that follows.
    task automatic send(input stdb_fab_word_s w);
        @(posedge clk);
        fab_word <= w;
        @(posedge clk);
        fab_word_toggle <= ~fab_word_toggle;
    endtask

    task automatic seek(input logic [19:0] pat, input logic [19:0] msk);
        hit = 1'b0;
        repeat (60) begin
            @(posedge clk);
            #1;
            if ((hist & msk) === pat) hit = 1'b1;
        end
    endtask

    task automatic watch(input int n);
        rl = 1'b0;
        st = 1'b0;
        rs = 0;
        rmax = 0;
        rmin = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            rl |= run_length_error;
            st |= self_test_error;
            rs += tx_serial_out ? 1 : -1;
            rmax = (rs > rmax) ? rs : rmax;
            rmin = (rs < rmin) ? rs : rmin;
        end
    endtask

    initial begin
        rst_n = 1'b0;
        fab_word = '0;
        fab_word_toggle = 1'b0;
        cfg = '0;
        self_test_enable = 1'b0;
        ref_clk_in = 4'h0;
        master_channel_tx_clock = 1'b0;
        corrupt = 1'b0;
        cyc(4);
        rst_n <= 1'b1;
        cyc(4);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cfg.ref_sel <= stdb_refsel_e'(i[1:0]);
            cfg.fifo_enable <= i[0];
            ref_clk_in <= 4'h1 << i;
            cyc(8);
            chk(tx_reference_clock, 1'b1, "reference select");
            chk(channel_clock, 1'b1, "channel from reference");
            chk(mux_clock_source, i[0], "multiplexer clock");
        end
        cfg.chan_clk_sel <= 1'b1;
        cyc(8);
        chk(channel_clock, 1'b0, "channel from master low");
        master_channel_tx_clock <= 1'b1;
        cyc(8);
        chk(channel_clock, 1'b1, "channel from master high");
        $display("test clocks done");
        cfg.xaui_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cfg.mult_factor <= mults[i];
            cyc(8);
            chk(pll_cfg_error, 20'(i == 0 || i == 3), "multiplier range");
        end
        cfg.mult_factor <= 5'h0A;
        cfg.enc_bypass <= 1'b1;
        cfg.word_width_10 <= 1'b1;
        cyc(12);
        send({2'h0, 20'h0_03E0});
        seek(20'h5_57E0, 20'hF_FFFF);
        chk(hit, 1'b1, "raw word after idle");
        send({2'h0, 20'h0_03FE});
        watch(60);
        chk(rl, 1'b0, "run of ten");
        send({2'h0, 20'h0_03FF});
        watch(60);
        chk(rl, 1'b1, "run of eleven");
        // Start the window on an edge so both ends see the counters at the same point of the update.
        cyc(1);
        w0 = wr;
        f0 = fr;
        cyc(200);
        chk(20'(wr - w0), 20'h0_0014, "word clock rate");
        chk(20'(fr - f0), 20'h0_0014, "fabric clock undivided");
        cfg.fab_div2 <= 1'b1;
        cyc(40);
        f0 = fr;
        cyc(200);
        chk(20'(fr - f0), 20'h0_000A, "fabric clock halved");
        cfg.double_width <= 1'b1;
        cyc(12);
        send({2'h0, 20'h3_E3E0});
        seek(20'hF_80F8, 20'hF_FFFF);
        chk(hit, 1'b1, "low half then high half");
        cfg.word_width_10 <= 1'b0;
        cyc(12);
        send({2'h0, 20'h0_F00F});
        seek(20'h5_0FF0, 20'hF_FFFF);
        chk(hit, 1'b1, "eight bit halves after idle");
        $display("test raw path done");
        @(posedge clk);
        cfg <= stdb_cfg_s'{xaui_mode: 1'b1, mult_factor: 5'h0A, ref_sel: REF_GLOBAL, default: 1'b0};
        cyc(12);
        seek(20'h0_001F, 20'h0_007F);
        chk(hit, 1'b1, "comma in idle");
        for (int i = 0; i < 3; i++) begin
            send({2'(i == 2), 12'h000, 8'(i == 1 ? 8'hFF : (i == 2 ? 8'hBC : 8'h00))});
            watch(40);
            chk(20'(rmax - rmin <= 6), 1'b1, "disparity balance");
            chk(rl, 1'b0, "encoded run length");
        end
        $display("test encoder done");
        cfg.line_loopback <= 1'b1;
        cfg.bist_width10 <= 1'b1;
        // Raw ten-bit words make a fabric word wrongly kept through self test show as an eleven-bit run.
        cfg.enc_bypass <= 1'b1;
        cfg.word_width_10 <= 1'b1;
        cyc(8);
        self_test_enable <= 1'b1;
        cyc(40);
        send({2'h0, 20'h0_03FF});
        watch(300);
        chk(st, 1'b0, "clean line loopback");
        chk(rl, 1'b0, "fabric word ignored");
        chk(tx_out_enable, 1'b1, "line loopback drives");
        corrupt <= 1'b1;
        @(posedge clk);
        corrupt <= 1'b0;
        cyc(12);
        chk(self_test_error, 1'b1, "error raised");
        cyc(60);
        chk(self_test_error, 1'b1, "error held");
        self_test_enable <= 1'b0;
        cyc(8);
        chk(self_test_error, 1'b0, "error cleared");
        watch(60);
        chk(rl, 1'b0, "fabric word dropped");
        cfg.line_loopback <= 1'b0;
        cfg.bist_width10 <= 1'b0;
        cyc(8);
        self_test_enable <= 1'b1;
        cyc(12);
        chk(tx_out_enable, 1'b0, "local loopback released");
        chk(tx_serial_out, 1'b0, "local loopback line");
        watch(300);
        chk(st, 1'b0, "clean local eight bit");
        self_test_enable <= 1'b0;
        $display("test self test done");
        final_report();
    end
endmodule
